// >>> hw/lvdgm_pkg.sv
// package of constants for the glitch-managing bus port controller
// assumes a single 100 MHz clock and no software-visible registers
package lvdgm_pkg;
    // ========================================================================
    // timing
    // ========================================================================
    localparam int CLK_PERIOD_NS = 10; // local clock period
    localparam int SETTLE_NS = 400; // bus settle delay
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUAL_MS = 100; // mode qualification interval
    localparam int QUAL_CYC = QUAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 24; // width of long timers
    // ========================================================================
    // mode codes from the four sense comparators (low, mid, high thresholds, LVD top)
    // ========================================================================
    localparam logic [1:0] MODE_SE = 2'h0;
    localparam logic [1:0] MODE_LVD = 2'h1;
    localparam logic [1:0] MODE_HVD = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h3; // indeterminate
    // ========================================================================
    // control line indices in the bus vector
    // ========================================================================
    localparam int LN_BSY = 0;
    localparam int LN_SEL = 1;
    localparam int LN_RST = 2;
    localparam int LN_ACK = 3;
    localparam int LN_ATN = 4;
    localparam int LN_REQ = 5;
    localparam int LN_CD = 6;
    localparam int LN_IO = 7;
    localparam int LN_MSG = 8;
    localparam int NCTL = 9;
    // ========================================================================
    // driver leg enables per line: {src4, src2, src1, src3}
    // ========================================================================
    localparam logic [3:0] LEG_ASSERT = 4'hC; // source 4 and source 2
    localparam logic [3:0] LEG_NEGATE = 4'h3; // source 1 and source 3
    localparam logic [3:0] LEG_OFF = 4'h0; // released, high impedance
endpackage : lvdgm_pkg

// >>> hw/lvdgm_mode_qual.sv
// mode sense qualifier: synchroniser, band decode, stability timers
// assumes sense comparator outputs are asynchronous levels
`timescale 1ns/100ps
module lvdgm_mode_qual #(
    parameter int QUAL_CYC = lvdgm_pkg::QUAL_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic senseAboveLow, // sense above SE band top
    input wire logic senseAboveMid, // sense at or above LVD band bottom
    input wire logic senseAboveHigh, // sense at or above HVD band bottom
    input wire logic senseBelowLvdTop, // sense at or below LVD band top
    output logic [1:0] qualMode, // qualified mode
    output logic driversReady // power-up and stability hold-off done
);
    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        logic [3:0] s1; // first sync stage
        logic [3:0] s2;
        logic [3:0] s3;
        logic [1:0] cand; // candidate mode being timed
        logic [lvdgm_pkg::CNT_W-1:0] candCnt; // candidate stable cycles
        logic [1:0] mode; // qualified mode
        logic [lvdgm_pkg::CNT_W-1:0] upCnt; // operational time
        logic upDone;
        logic [lvdgm_pkg::CNT_W-1:0] stabCnt; // stability after power-up
        logic ready;
    } lvdgm_qual_s;
    lvdgm_qual_s st_r, st_nxt;
    localparam logic [lvdgm_pkg::CNT_W-1:0] QLIM = lvdgm_pkg::CNT_W'(QUAL_CYC - 1);

    // decode the agreed comparator word into a band
    function automatic logic [1:0] band(input logic [3:0] c);
        if (!c[0])
            band = lvdgm_pkg::MODE_SE;
        else if (c[1] && c[3] && !c[2])
            band = lvdgm_pkg::MODE_LVD;
        else if (c[2])
            band = lvdgm_pkg::MODE_HVD;
        else
            band = lvdgm_pkg::MODE_NONE; // gaps count as no mode
    endfunction : band

    logic [1:0] seen;
    // ========================================================================
    // next state
    // ========================================================================
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = {senseBelowLvdTop, senseAboveHigh, senseAboveMid, senseAboveLow};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // only a level that stages two and three agree on counts
        seen = (st_r.s2 == st_r.s3) ? band(st_r.s3) : lvdgm_pkg::MODE_NONE;
        // new mode must be held unbroken for the full interval
        if (seen == lvdgm_pkg::MODE_NONE || seen != st_r.cand)
        begin
            st_nxt.cand = seen;
            st_nxt.candCnt = '0;
        end
        else if (st_r.candCnt != QLIM)
            st_nxt.candCnt = st_r.candCnt + 1'b1;
        else
            st_nxt.mode = st_r.cand;
        // operational interval first
        if (!st_r.upDone)
        begin
            if (st_r.upCnt == QLIM)
                st_nxt.upDone = 1'b1;
            else
                st_nxt.upCnt = st_r.upCnt + 1'b1;
        end
        // then stability of the detected mode
        else if (!st_r.ready)
        begin
            if (st_nxt.mode != st_r.mode || st_r.mode == lvdgm_pkg::MODE_NONE)
                st_nxt.stabCnt = '0;
            else if (st_r.stabCnt == QLIM)
                st_nxt.ready = 1'b1;
            else
                st_nxt.stabCnt = st_r.stabCnt + 1'b1;
        end
    end

    // ========================================================================
    // registers
    // ========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= '0;
            st_r.cand <= lvdgm_pkg::MODE_NONE;
            st_r.mode <= lvdgm_pkg::MODE_NONE;
        end
        else
            st_r <= st_nxt;
    end

    assign qualMode = st_r.mode;
    assign driversReady = st_r.ready;

    // drivers never ready before the operational interval
    a_ready_after_up: assert property (@(posedge clk) disable iff (!resetn)
        st_r.ready |-> st_r.upDone)
        else $error("drivers ready before operational interval");
    // qualified mode only changes to the candidate at full count
    a_mode_change_qual: assert property (@(posedge clk) disable iff (!resetn)
        (st_r.mode != $past(st_r.mode)) |-> ($past(st_r.candCnt) == QLIM))
        else $error("mode changed without full qualification");
endmodule : lvdgm_mode_qual

// >>> hw/lvdgm_port_ctrl.sv
// bus port controller: mode gating, driver legs and release glitch timing
// assumes protocol logic gives desired line values and role; bus pins via
// comparator inputs (asynchronous) and per-line driver leg enables
`timescale 1ns/100ps
module lvdgm_port_ctrl #(
    parameter int SETTLE_CYC = lvdgm_pkg::SETTLE_CYC,
    parameter int QUAL_CYC = lvdgm_pkg::QUAL_CYC,
    parameter int DW = 18 // data plus parity lines
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic senseAboveLow,
    input wire logic senseAboveMid,
    input wire logic senseAboveHigh,
    input wire logic senseBelowLvdTop,
    input wire logic roleTarget, // 1 target, 0 initiator
    input wire logic selPhase, // selection or reselection in progress
    input wire logic [lvdgm_pkg::NCTL-1:0] ctlWant, // desired asserted lines
    input wire logic [lvdgm_pkg::NCTL-1:0] ctlOwn, // lines this end drives
    input wire logic dataDrive, // protocol wants data bus driven
    input wire logic [DW-1:0] dataWant,
    input wire logic [lvdgm_pkg::NCTL-1:0] ctlIn, // received control lines
    output logic [4*lvdgm_pkg::NCTL-1:0] ctlLegs, // 4 legs per control line
    output logic [4*DW-1:0] dataLegs, // 4 legs per data line
    output logic [lvdgm_pkg::NCTL-1:0] ctlSeen, // qualified received lines
    output logic busFree,
    output logic [1:0] busMode,
    output logic termLvd, // terminator in LVD mode
    output logic termSe, // terminator in SE mode
    output logic gndDrvOn // ground drivers enabled
);
    // ========================================================================
    // mode qualifier
    // ========================================================================
    logic [1:0] qMode;
    logic ready;
    lvdgm_mode_qual #(.QUAL_CYC(QUAL_CYC)) uQual (
        .clk(clk),
        .resetn(resetn),
        .senseAboveLow(senseAboveLow),
        .senseAboveMid(senseAboveMid),
        .senseAboveHigh(senseAboveHigh),
        .senseBelowLvdTop(senseBelowLvdTop),
        .qualMode(qMode),
        .driversReady(ready)
    );

    // ========================================================================
    // state
    // ========================================================================
    localparam int TW = 16;
    localparam logic [TW-1:0] T_SET = TW'(SETTLE_CYC);
    localparam logic [TW-1:0] T_REQ = TW'((5 * SETTLE_CYC + 1) / 2); // 2.5 settles
    localparam logic [TW-1:0] T_IGN = TW'(SETTLE_CYC); // well inside 1.5 settles

    typedef struct packed {
        logic [lvdgm_pkg::NCTL-1:0] s1; // first sync stage
        logic [lvdgm_pkg::NCTL-1:0] s2;
        logic [lvdgm_pkg::NCTL-1:0] s3;
        logic [lvdgm_pkg::NCTL-1:0] seen; // debounced received lines
        logic [TW-1:0] freeCnt; // cycles with BSY and SEL false
        logic free;
        logic [TW-1:0] relCnt; // cycles since own BSY released
        logic bsyOwnPrev;
        logic ignAckAtn; // target ignoring ACK, ATN
        logic [TW-1:0] inCnt; // cycles since BSY seen false
        logic ignReq; // initiator ignoring REQ
        logic bsySeenPrev;
        logic reqHold; // REQ kept negated
        logic cdHold; // C/D, I/O, MSG kept negated
    } lvdgm_ctl_s;
    lvdgm_ctl_s st_r, st_nxt;

    function automatic logic [3:0] legs(input logic on, input logic neg, input logic val);
        if (!on)
            legs = lvdgm_pkg::LEG_OFF;
        else if (val)
            legs = lvdgm_pkg::LEG_ASSERT;
        else if (neg)
            legs = lvdgm_pkg::LEG_NEGATE;
        else
            legs = lvdgm_pkg::LEG_OFF;
    endfunction : legs

    function automatic logic [TW-1:0] sat(input logic [TW-1:0] c);
        sat = (c == {TW{1'b1}}) ? c : c + 1'b1;
    endfunction : sat

    // ========================================================================
    // next state: synchroniser, bus free, glitch timers
    // ========================================================================
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = ctlIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < lvdgm_pkg::NCTL; i++)
            if (st_r.s2[i] == st_r.s3[i])
                st_nxt.seen[i] = st_r.s3[i];
        // bus free a settle delay after BSY and SEL both false
        if (st_r.seen[lvdgm_pkg::LN_BSY] || st_r.seen[lvdgm_pkg::LN_SEL])
        begin
            st_nxt.freeCnt = '0;
            st_nxt.free = 1'b0;
        end
        else if (st_r.freeCnt >= T_SET - 1'b1)
            st_nxt.free = 1'b1;
        else
            st_nxt.freeCnt = st_r.freeCnt + 1'b1;
        // target: timers from own BSY release
        st_nxt.bsyOwnPrev = ctlWant[lvdgm_pkg::LN_BSY] & ctlOwn[lvdgm_pkg::LN_BSY];
        if (st_nxt.bsyOwnPrev)
        begin
            st_nxt.relCnt = '0;
            st_nxt.ignAckAtn = 1'b0; // connection held, listen again
            st_nxt.reqHold = roleTarget;
            st_nxt.cdHold = roleTarget && selPhase;
        end
        else
        begin
            st_nxt.relCnt = sat(st_r.relCnt);
            st_nxt.cdHold = 1'b0; // BSY released, may release
            if (roleTarget && st_r.bsyOwnPrev)
                st_nxt.ignAckAtn = 1'b1;
            if (st_r.relCnt >= T_REQ - 1'b1)
                st_nxt.reqHold = 1'b0;
        end
        // initiator: ignore REQ after BSY true to false
        st_nxt.bsySeenPrev = st_r.seen[lvdgm_pkg::LN_BSY];
        if (st_r.seen[lvdgm_pkg::LN_BSY])
        begin
            st_nxt.inCnt = '0;
            if (!st_r.ignReq || st_r.free)
                st_nxt.ignReq = 1'b0;
        end
        else
        begin
            st_nxt.inCnt = sat(st_r.inCnt);
            if (!roleTarget && st_r.inCnt >= T_IGN - 1'b1)
                st_nxt.ignReq = 1'b1;
        end
        if (st_r.seen[lvdgm_pkg::LN_BSY] && !st_r.bsySeenPrev)
            st_nxt.ignReq = 1'b0; // new connection
    end

    // ========================================================================
    // registers
    // ========================================================================
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // ========================================================================
    // driver legs; high impedance until ready and in SE or LVD mode
    // ========================================================================
    logic drvOk;
    logic [lvdgm_pkg::NCTL-1:0] negOk;
    logic [lvdgm_pkg::NCTL-1:0] ctlOn;
    always_comb
    begin
        drvOk = ready && (qMode == lvdgm_pkg::MODE_SE || qMode == lvdgm_pkg::MODE_LVD);
        // BSY, SEL, RST never actively negated
        negOk = '1;
        negOk[lvdgm_pkg::LN_BSY] = 1'b0;
        negOk[lvdgm_pkg::LN_SEL] = 1'b0;
        negOk[lvdgm_pkg::LN_RST] = 1'b0;
        ctlOn = ctlOwn;
        // initiator ACK, ATN stay driven until bus free, negated unless wanted and owned
        if (!roleTarget && !st_r.free)
        begin
            ctlOn[lvdgm_pkg::LN_ACK] = 1'b1;
            ctlOn[lvdgm_pkg::LN_ATN] = 1'b1;
        end
        if (st_r.reqHold)
            ctlOn[lvdgm_pkg::LN_REQ] = 1'b1;
        if (st_r.cdHold)
        begin
            ctlOn[lvdgm_pkg::LN_CD] = 1'b1;
            ctlOn[lvdgm_pkg::LN_IO] = 1'b1;
            ctlOn[lvdgm_pkg::LN_MSG] = 1'b1;
        end
        for (int i = 0; i < lvdgm_pkg::NCTL; i++)
            ctlLegs[4*i +: 4] = legs(drvOk && ctlOn[i], negOk[i], ctlWant[i] && ctlOwn[i]);
        // selection data zeros released, transfer data actively negated
        for (int j = 0; j < DW; j++)
            dataLegs[4*j +: 4] = legs(drvOk && dataDrive, !selPhase, dataWant[j]);
    end

    // received lines with ignore masks applied
    always_comb
    begin
        ctlSeen = st_r.seen;
        if (st_r.ignAckAtn)
        begin
            ctlSeen[lvdgm_pkg::LN_ACK] = 1'b0;
            ctlSeen[lvdgm_pkg::LN_ATN] = 1'b0;
        end
        if (st_r.ignReq)
            ctlSeen[lvdgm_pkg::LN_REQ] = 1'b0;
    end

    assign busFree = st_r.free;
    assign busMode = qMode;
    assign termLvd = qMode == lvdgm_pkg::MODE_LVD;
    assign termSe = qMode == lvdgm_pkg::MODE_SE;
    assign gndDrvOn = qMode == lvdgm_pkg::MODE_SE;

    // ========================================================================
    // checks
    // ========================================================================
    a_bsy_no_negate: assert property (@(posedge clk) disable iff (!resetn)
        ctlLegs[4*lvdgm_pkg::LN_BSY +: 4] != lvdgm_pkg::LEG_NEGATE)
        else $error("BSY actively negated");
    a_hvd_all_off: assert property (@(posedge clk) disable iff (!resetn)
        (qMode == lvdgm_pkg::MODE_HVD || !ready) |-> (ctlLegs == '0 && dataLegs == '0))
        else $error("driver enabled in HVD or before ready");
    a_free_needs_idle: assert property (@(posedge clk) disable iff (!resetn)
        $rose(st_r.free) |-> $past(!st_r.seen[lvdgm_pkg::LN_BSY] && !st_r.seen[lvdgm_pkg::LN_SEL]))
        else $error("bus free without idle lines");
    a_ack_held_init: assert property (@(posedge clk) disable iff (!resetn)
        (ready && !roleTarget && !st_r.free && qMode != lvdgm_pkg::MODE_HVD && qMode != lvdgm_pkg::MODE_NONE
         && !ctlWant[lvdgm_pkg::LN_ACK]) |-> ctlLegs[4*lvdgm_pkg::LN_ACK +: 4] == lvdgm_pkg::LEG_NEGATE)
        else $error("initiator ACK released before bus free");
    a_ignore_ack: assert property (@(posedge clk) disable iff (!resetn)
        (roleTarget && $fell(st_r.bsyOwnPrev)) |-> ##1 st_r.ignAckAtn)
        else $error("target not ignoring ACK after BSY release");
    a_req_hold_time: assert property (@(posedge clk) disable iff (!resetn)
        $fell(st_r.reqHold) |-> $past(st_r.relCnt) >= T_REQ - 1'b1)
        else $error("REQ released too early");
    a_req_ignore: assert property (@(posedge clk) disable iff (!resetn)
        (!roleTarget && st_r.inCnt == T_IGN && !st_r.seen[lvdgm_pkg::LN_BSY]) |-> st_r.ignReq)
        else $error("initiator not ignoring REQ in time");
    a_sel_data_zero: assert property (@(posedge clk) disable iff (!resetn)
        selPhase |-> !(dataLegs[3:0] == lvdgm_pkg::LEG_NEGATE))
        else $error("selection data bit actively negated");
    a_gnd_se: assert property (@(posedge clk) disable iff (!resetn)
        gndDrvOn == (busMode == lvdgm_pkg::MODE_SE))
        else $error("ground driver mismatch");
endmodule : lvdgm_port_ctrl

// >>> tb/lvdgm_bus_model.sv
// far side of the port: other parties on the bus and the sense line
// assumes the bench picks a sense band and the lines the others assert
`timescale 1ns/100ps
module lvdgm_bus_model #(
    parameter int GLITCH_CYC = 3 // release glitch length, below one settle
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] senseBand, // 0 SE, 1 gap, 2 LVD, 3 gap, 4 HVD
    input wire logic [lvdgm_pkg::NCTL-1:0] otherAssert, // asserted by others
    input wire logic [4*lvdgm_pkg::NCTL-1:0] ctlLegs,
    output logic senseAboveLow,
    output logic senseAboveMid,
    output logic senseAboveHigh,
    output logic senseBelowLvdTop,
    output logic [lvdgm_pkg::NCTL-1:0] ctlIn
);
    // ========================================================================
    // sense comparators
    // ========================================================================
    // gaps sit between the bands, so a gap trips an odd comparator pattern
    assign senseAboveLow = (senseBand >= 3'h1);
    assign senseAboveMid = (senseBand >= 3'h2);
    assign senseAboveHigh = (senseBand == 3'h4);
    assign senseBelowLvdTop = (senseBand <= 3'h2);
    // ========================================================================
    // wired bus lines
    // ========================================================================
    logic [lvdgm_pkg::NCTL-1:0] wasNegated; // line was actively negated
    int glitchLeft [lvdgm_pkg::NCTL]; // cycles of glitch still to show
    // a line let go from active negation flickers true, as real wire does
    always @(posedge clk)
    begin
        for (int i = 0; i < lvdgm_pkg::NCTL; i++)
        begin
            if (!resetn)
            begin
                glitchLeft[i] <= 0;
            end
            else if (wasNegated[i] && ctlLegs[4*i +: 4] == lvdgm_pkg::LEG_OFF)
            begin
                glitchLeft[i] <= GLITCH_CYC;
            end
            else if (glitchLeft[i] > 0)
            begin
                glitchLeft[i] <= glitchLeft[i] - 1;
            end
            wasNegated[i] <= resetn && ctlLegs[4*i +: 4] == lvdgm_pkg::LEG_NEGATE;
        end
    end
    // line reads true if anyone asserts it or it is glitching
    always_comb
    begin
        for (int i = 0; i < lvdgm_pkg::NCTL; i++)
        begin
            ctlIn[i] = otherAssert[i] || glitchLeft[i] > 0
                || ctlLegs[4*i +: 4] == lvdgm_pkg::LEG_ASSERT;
        end
    end
endmodule : lvdgm_bus_model

// >>> tb/lvdgm_port_ctrl_bench.sv
// self-checking bench of the port controller with short timers
// assumes the bus model above stands for every other party
`timescale 1ns/100ps
module lvdgm_port_ctrl_bench;
    localparam int SETTLE = 4; // short settle delay
    localparam int QUAL = 20; // short qualification interval
    logic clk, resetn, roleTarget, selPhase, dataDrive;
    logic sLow, sMid, sHigh, sTop, busFree, termLvd, termSe, gndDrvOn;
    logic [lvdgm_pkg::NCTL-1:0] ctlWant, ctlOwn, ctlIn, ctlSeen, otherAssert;
    logic [4*lvdgm_pkg::NCTL-1:0] ctlLegs;
    logic [17:0] dataWant;
    logic [71:0] dataLegs;
    logic [1:0] busMode;
    logic [2:0] senseBand;
    logic [31:0] seed; // random source state
    int errors, nCompared;
    lvdgm_port_ctrl #(.SETTLE_CYC(SETTLE), .QUAL_CYC(QUAL), .DW(18)) u_lvdgm_port_ctrl (
        .clk(clk), .resetn(resetn), .senseAboveLow(sLow), .senseAboveMid(sMid),
        .senseAboveHigh(sHigh), .senseBelowLvdTop(sTop), .roleTarget(roleTarget),
        .selPhase(selPhase), .ctlWant(ctlWant), .ctlOwn(ctlOwn), .dataDrive(dataDrive),
        .dataWant(dataWant), .ctlIn(ctlIn), .ctlLegs(ctlLegs), .dataLegs(dataLegs),
        .ctlSeen(ctlSeen), .busFree(busFree), .busMode(busMode), .termLvd(termLvd),
        .termSe(termSe), .gndDrvOn(gndDrvOn));
    lvdgm_bus_model #(.GLITCH_CYC(3)) u_lvdgm_bus_model (
        .clk(clk), .resetn(resetn), .senseBand(senseBand), .otherAssert(otherAssert),
        .ctlLegs(ctlLegs), .senseAboveLow(sLow), .senseAboveMid(sMid),
        .senseAboveHigh(sHigh), .senseBelowLvdTop(sTop), .ctlIn(ctlIn));
    // ========================================================================
    // helpers
    // ========================================================================
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chkVal(input string what, input logic [3:0] exp, input logic [3:0] got);
        nCompared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chkVal
    task automatic chkFlag(input string what, input logic exp, input logic got);
        chkVal(what, {3'h0, exp}, {3'h0, got});
    endtask : chkFlag
    function automatic logic [3:0] leg(input int i);
        return ctlLegs[4*i +: 4];
    endfunction : leg
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
    endfunction : lfsr
    // selection drops zeros to released, transfers negate them
    function automatic logic [3:0] expData(input logic w, input logic sel, input logic drv);
        if (!drv) return lvdgm_pkg::LEG_OFF;
        if (w) return lvdgm_pkg::LEG_ASSERT;
        return sel ? lvdgm_pkg::LEG_OFF : lvdgm_pkg::LEG_NEGATE;
    endfunction : expData
    task automatic end_sim;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic holdBand(input logic [2:0] b, input int n);
        senseBand = b;
        cyc(n);
    endtask : holdBand
    // ========================================================================
    // clock, watchdog, main sequence
    // ========================================================================
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is under a thousand cycles, so five thousand means a hang
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end
    initial
    begin
        {resetn, roleTarget, selPhase, dataDrive} = 4'h1;
        ctlWant = '1;
        ctlOwn = '1;
        otherAssert = '0;
        dataWant = '1;
        senseBand = 3'h2;
        seed = 32'hD043;
        errors = 0;
        nCompared = 0;
        resetn = 1'b0;
        cyc(16);
        chkVal("mode in reset", 4'h3, {2'h0, busMode});
        chkFlag("ground in reset", 1'b0, gndDrvOn);
        resetn = 1'b1;
        for (int k = 0; k < 2 * QUAL; k++)
        begin
            cyc(1);
            chkFlag("legs off", 1'b1, ctlLegs === '0 && dataLegs === '0);
        end
        cyc(12);
        chkVal("ack assert", lvdgm_pkg::LEG_ASSERT, leg(lvdgm_pkg::LN_ACK));
        chkVal("mode lvd", 4'h1, {2'h0, busMode});
        $display("test powerup done");
        // target holding its own busy, others assert ack
        roleTarget = 1'b1;
        ctlWant = 9'h001;
        ctlOwn = 9'h1E7;
        otherAssert = 9'h008;
        cyc(8);
        chkFlag("ack seen", 1'b1, ctlSeen[lvdgm_pkg::LN_ACK]);
        chkVal("sel off", lvdgm_pkg::LEG_OFF, leg(lvdgm_pkg::LN_SEL));
        chkVal("rst off", lvdgm_pkg::LEG_OFF, leg(lvdgm_pkg::LN_RST));
        for (int i = 5; i < 9; i++)
            chkVal("neg line", lvdgm_pkg::LEG_NEGATE, leg(i));
        for (int n = 0; n < 16; n++)
        begin
            seed = lfsr(seed);
            dataWant = seed[17:0];
            selPhase = seed[20];
            dataDrive = seed[24] | seed[3];
            cyc(1);
            for (int b = 0; b < 18; b++)
                chkVal("data leg", expData(dataWant[b], selPhase, dataDrive),
                       dataLegs[4*b +: 4]);
        end
        $display("test target data done");
        selPhase = 1'b1;
        // only BSY, SEL, RST owned, so REQ and C/D show the hold logic alone
        ctlOwn = 9'h007;
        cyc(2);
        chkVal("cd held", lvdgm_pkg::LEG_NEGATE, leg(lvdgm_pkg::LN_CD));
        ctlWant = 9'h000;
        for (int k = 1; k < 10; k++)
        begin
            cyc(1);
            chkVal("req held", lvdgm_pkg::LEG_NEGATE, leg(lvdgm_pkg::LN_REQ));
        end
        chkFlag("ack ignored", 1'b0, ctlSeen[lvdgm_pkg::LN_ACK]);
        cyc(5);
        chkVal("req off", lvdgm_pkg::LEG_OFF, leg(lvdgm_pkg::LN_REQ));
        chkVal("cd off", lvdgm_pkg::LEG_OFF, leg(lvdgm_pkg::LN_CD));
        $display("test target release done");
        // initiator watching another target
        {roleTarget, selPhase, dataDrive} = 3'h0;
        // ACK, ATN not owned: only the bus-free hold may drive them
        ctlOwn = 9'h000;
        otherAssert = 9'h021;
        cyc(8);
        chkVal("ack neg", lvdgm_pkg::LEG_NEGATE, leg(lvdgm_pkg::LN_ACK));
        chkFlag("req seen", 1'b1, ctlSeen[lvdgm_pkg::LN_REQ]);
        otherAssert = 9'h020;
        cyc(SETTLE);
        chkFlag("not free yet", 1'b0, busFree);
        chkVal("atn neg", lvdgm_pkg::LEG_NEGATE, leg(lvdgm_pkg::LN_ATN));
        cyc(6);
        chkFlag("req ignored", 1'b0, ctlSeen[lvdgm_pkg::LN_REQ]);
        cyc(2);
        chkFlag("bus free", 1'b1, busFree);
        chkVal("ack off", lvdgm_pkg::LEG_OFF, leg(lvdgm_pkg::LN_ACK));
        $display("test initiator done");
        // mode changes with every owned line asserted
        ctlWant = '1;
        ctlOwn = '1;
        otherAssert = '0;
        dataDrive = 1'b1;
        holdBand(3'h1, QUAL + 8);
        chkVal("gap keeps mode", 4'h1, {2'h0, busMode});
        holdBand(3'h0, QUAL - 4);
        holdBand(3'h2, QUAL + 8);
        chkVal("short se", 4'h1, {2'h0, busMode});
        holdBand(3'h0, QUAL + 8);
        chkVal("mode se", 4'h0, {2'h0, busMode});
        chkFlag("ground on", 1'b1, gndDrvOn);
        chkFlag("term se", 1'b1, termSe);
        holdBand(3'h4, QUAL + 8);
        chkVal("mode hvd", 4'h2, {2'h0, busMode});
        chkFlag("hvd off", 1'b1, ctlLegs === '0 && dataLegs === '0);
        chkFlag("ground off", 1'b0, gndDrvOn);
        holdBand(3'h3, QUAL + 8);
        chkVal("gap keeps hvd", 4'h2, {2'h0, busMode});
        holdBand(3'h2, QUAL + 8);
        chkFlag("term lvd", 1'b1, termLvd);
        chkFlag("term not se", 1'b0, termSe);
        $display("test modes done");
        end_sim();
    end
endmodule : lvdgm_port_ctrl_bench
